// file: hdl/select_decode_pkg.sv
// How it works
// - eight select outputs; zero to six assert when the bus address is in their chosen window, seven never does
// - output zero: 00 F00000 up, 01 F80000 up, 10 FE0000 up, 11 off
// - output zero also asserts on program and vector fetches inside its window
// - output one: E00000, F00000, FC0000 windows, or 68FF80 128-byte window
// - output two: 003000 4k, FA0000 128k, 68FF80 or 68FF00 128-byte windows
// - output three: F80000 128k, 68FF00, 68FE80 windows; code 11 off
// - output four: 002800 2k, 68FE80 128 bytes; codes 10 and 11 off
// - output five: only code 00, window 68FF80 to 68FFFF
// - output six: only code 00, window 68FF00 to 68FF7F
// - output seven never asserts
package select_decode_pkg;
   localparam int          ADDR_W        = 24;
   localparam int          NUM_SEL       = 8;
   localparam logic [11:0] APB_CTRL_OFS  = 12'h000;
   localparam logic [11:0] APB_STAT_OFS  = 12'h004;
   localparam logic [15:0] CODE_RESET    = 16'hffff;
   localparam logic [23:0] W_E00000      = 24'he00000;
   localparam logic [23:0] W_F00000      = 24'hf00000;
   localparam logic [23:0] W_F80000      = 24'hf80000;
   localparam logic [23:0] W_FA0000      = 24'hfa0000;
   localparam logic [23:0] W_FC0000      = 24'hfc0000;
   localparam logic [23:0] W_FE0000      = 24'hfe0000;
   localparam logic [23:0] W_68FE80      = 24'h68fe80;
   localparam logic [23:0] W_68FF00      = 24'h68ff00;
   localparam logic [23:0] W_68FF80      = 24'h68ff80;
   localparam logic [23:0] W_003000      = 24'h003000;
   localparam logic [23:0] W_002800      = 24'h002800;
   localparam logic [23:0] SZ_1M         = 24'h100000;
   localparam logic [23:0] SZ_512K       = 24'h080000;
   localparam logic [23:0] SZ_128K       = 24'h020000;
   localparam logic [23:0] SZ_4K         = 24'h001000;
   localparam logic [23:0] SZ_2K         = 24'h000800;
   localparam logic [23:0] SZ_128        = 24'h000080;
   localparam logic [1:0]  CODE_00       = 2'h0;
   localparam logic [1:0]  CODE_01       = 2'h1;
   localparam logic [1:0]  CODE_10       = 2'h2;
   localparam logic [1:0]  CODE_11       = 2'h3;
endpackage

// file: hdl/chip_select_decoder.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module chip_select_decoder
   import select_decode_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                bus_valid,
   input  wire logic [ADDR_W-1:0]   bus_addr,
   input  wire logic                fetch_access,
   output logic                     select_out_zero,
   output logic                     select_out_one,
   output logic                     select_out_two,
   output logic                     select_out_three,
   output logic                     select_out_four,
   output logic                     select_out_five,
   output logic                     select_out_six,
   output logic                     select_out_seven
);

   // half-open window test; base and size stay aligned so no wrap occurs
   function automatic logic in_win(input logic [23:0] a, input logic [23:0] b,
                                   input logic [23:0] s);
      in_win = (a >= b) && ((a - b) < s);
   endfunction

   // two area code bits per output, output n in bits 2n+1:2n
   logic [15:0] area_code_field_r;
   logic [7:0]  sel_r;
   logic [7:0]  sel_nxt;

   wire        acc_w    = psel & penable;
   wire        hit_ctrl = paddr == APB_CTRL_OFS;
   wire        hit_stat = paddr == APB_STAT_OFS;
   wire        bad_addr = acc_w & ~hit_ctrl & ~hit_stat;
   wire [1:0]  c0 = area_code_field_r[1:0];
   wire [1:0]  c1 = area_code_field_r[3:2];
   wire [1:0]  c2 = area_code_field_r[5:4];
   wire [1:0]  c3 = area_code_field_r[7:6];
   wire [1:0]  c4 = area_code_field_r[9:8];
   wire [1:0]  c5 = area_code_field_r[11:10];
   wire [1:0]  c6 = area_code_field_r[13:12];
   wire [23:0] a  = bus_addr;

   // fetches are ordinary accesses for output zero; the same window applies
   wire s0 = (c0 == CODE_00 && in_win(a, W_F00000, SZ_1M))
           | (c0 == CODE_01 && in_win(a, W_F80000, SZ_512K))
           | (c0 == CODE_10 && in_win(a, W_FE0000, SZ_128K));
   wire s1 = (c1 == CODE_00 && in_win(a, W_E00000, SZ_1M))
           | (c1 == CODE_01 && in_win(a, W_F00000, SZ_512K))
           | (c1 == CODE_10 && in_win(a, W_FC0000, SZ_128K))
           | (c1 == CODE_11 && in_win(a, W_68FF80, SZ_128));
   wire s2 = (c2 == CODE_00 && in_win(a, W_003000, SZ_4K))
           | (c2 == CODE_01 && in_win(a, W_FA0000, SZ_128K))
           | (c2 == CODE_10 && in_win(a, W_68FF80, SZ_128))
           | (c2 == CODE_11 && in_win(a, W_68FF00, SZ_128));
   wire s3 = (c3 == CODE_00 && in_win(a, W_F80000, SZ_128K))
           | (c3 == CODE_01 && in_win(a, W_68FF00, SZ_128))
           | (c3 == CODE_10 && in_win(a, W_68FE80, SZ_128));
   wire s4 = (c4 == CODE_00 && in_win(a, W_002800, SZ_2K))
           | (c4 == CODE_01 && in_win(a, W_68FE80, SZ_128));
   wire s5 = (c5 == CODE_00 && in_win(a, W_68FF80, SZ_128));
   wire s6 = (c6 == CODE_00 && in_win(a, W_68FF00, SZ_128));

   // each output gated by bus_valid as well as its own window; output seven tied low
   assign sel_nxt = bus_valid ? {1'b0, s6, s5, s4, s3, s2, s1, s0} : 8'h00;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         area_code_field_r <= CODE_RESET;
      end else if (acc_w && pwrite && hit_ctrl) begin
         area_code_field_r <= pwdata[15:0];
      end
   end

   // registered selects: one cycle after the address, glitch free at the pins
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sel_r <= 8'h00;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = bad_addr;
   assign prdata  = hit_ctrl ? {16'h0000, area_code_field_r} :
                    hit_stat ? {24'h000000, sel_r} : 32'h00000000;

   assign select_out_zero  = sel_r[0];
   assign select_out_one   = sel_r[1];
   assign select_out_two   = sel_r[2];
   assign select_out_three = sel_r[3];
   assign select_out_four  = sel_r[4];
   assign select_out_five  = sel_r[5];
   assign select_out_six   = sel_r[6];
   assign select_out_seven = sel_r[7];

   chk_out7_never: assert property (@(posedge core_clk) disable iff (rst)
      !select_out_seven) else $error("output seven asserted");
   chk_zero_top: assert property (@(posedge core_clk) disable iff (rst)
      bus_valid && c0 == CODE_10 && a >= W_FE0000 |=> select_out_zero)
      else $error("output zero missed top window");
   chk_zero_fetch: assert property (@(posedge core_clk) disable iff (rst)
      bus_valid && fetch_access && c0 == CODE_00 && a >= W_F00000 |=> select_out_zero)
      else $error("output zero missed fetch");
   chk_zero_off: assert property (@(posedge core_clk) disable iff (rst)
      c0 == CODE_11 && $stable(c0) |=> !select_out_zero)
      else $error("output zero active while off");
   chk_one_small: assert property (@(posedge core_clk) disable iff (rst)
      bus_valid && c1 == CODE_11 |=> select_out_one == (a[23:7] == W_68FF80[23:7]) ||
      $past(a) != a || !$stable(c1))
      else $error("output one small window wrong");
   chk_two_low: assert property (@(posedge core_clk) disable iff (rst)
      bus_valid && c2 == CODE_00 && a[23:12] == W_003000[23:12] |=> select_out_two)
      else $error("output two missed 4k window");
   chk_three_off: assert property (@(posedge core_clk) disable iff (rst)
      c3 == CODE_11 |=> !select_out_three || !$stable(c3))
      else $error("output three active while off");
   chk_four_high: assert property (@(posedge core_clk) disable iff (rst)
      c4[1] |=> !select_out_four || !$stable(c4)) else $error("output four not off");
   chk_five_only: assert property (@(posedge core_clk) disable iff (rst)
      select_out_five |-> $past(c5) == CODE_00) else $error("output five bad code");
   chk_six_only: assert property (@(posedge core_clk) disable iff (rst)
      select_out_six |-> $past(c6) == CODE_00 && $past(a[23:7]) == W_68FF00[23:7])
      else $error("output six outside window");
   chk_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
      !bus_valid |=> sel_r == 8'h00) else $error("select without access");
   chk_overlap_both: assert property (@(posedge core_clk) disable iff (rst)
      bus_valid && c1 == CODE_11 && c5 == CODE_00 && a[23:7] == W_68FF80[23:7]
      |=> select_out_one && select_out_five) else $error("overlap lost");

   cov_zero_hit:  cover property (@(posedge core_clk) disable iff (rst) select_out_zero);
   cov_overlap:   cover property (@(posedge core_clk) disable iff (rst)
      select_out_two && select_out_five);
   cov_cfg_write: cover property (@(posedge core_clk) disable iff (rst)
      acc_w && pwrite && hit_ctrl);
   cov_four_hit:  cover property (@(posedge core_clk) disable iff (rst) select_out_four);

endmodule

// file: dv/ext_devices.sv
`timescale 1ns/1ps
module ext_devices (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] sel,
   output logic      [7:0] seen
);
   // each device only remembers that it was ever selected; line seven must stay dark
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         seen <= 8'h00;
      end else begin
         seen <= seen | sel;
      end
   end
endmodule

// file: dv/chip_select_decoder_tb_top.sv
`timescale 1ns/1ps
module chip_select_decoder_tb_top;
   import select_decode_pkg::*;
   localparam logic [23:0] nil = 24'h0;
   logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, bus_valid, fetch_access;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, seed;
   logic [23:0] bus_addr;
   logic [15:0] codes;
   logic [7:0]  sel, seen, e;
   logic        err;
   int          num_errors, comparisons;
   // window starts and ends plus one; stimulus lands a few bytes either side
   logic [23:0] pts [14] = '{24'he00000, 24'hf00000, 24'hf80000, 24'hfa0000, 24'hfc0000,
      24'hfe0000, 24'h68fe80, 24'h68ff00, 24'h68ff80, 24'h690000, 24'h002800, 24'h003000,
      24'h004000, 24'h000000};
   chip_select_decoder dut_u (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .bus_valid, .bus_addr, .fetch_access,
      .select_out_zero(sel[0]), .select_out_one(sel[1]), .select_out_two(sel[2]),
      .select_out_three(sel[3]), .select_out_four(sel[4]), .select_out_five(sel[5]),
      .select_out_six(sel[6]), .select_out_seven(sel[7]));
   ext_devices devs_u (.core_clk, .rst, .sel, .seen);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // 25-bit compare so the window reaching the top of memory does not wrap
   function automatic logic pk(logic [1:0] c, logic [23:0] a, logic [95:0] b, logic [95:0] s);
      return {1'b0, a} >= {1'b0, b[24*c +: 24]} && {1'b0, a} < {1'b0, b[24*c +: 24]} + s[24*c +: 24];
   endfunction
   function automatic logic [7:0] exp_sel(logic [15:0] c, logic [23:0] a);
      logic [7:0] s;
      s[0] = pk(c[1:0], a, {nil, W_FE0000, W_F80000, W_F00000}, {nil, SZ_128K, SZ_512K, SZ_1M});
      s[1] = pk(c[3:2], a, {W_68FF80, W_FC0000, W_F00000, W_E00000}, {SZ_128, SZ_128K, SZ_512K, SZ_1M});
      s[2] = pk(c[5:4], a, {W_68FF00, W_68FF80, W_FA0000, W_003000}, {SZ_128, SZ_128, SZ_128K, SZ_4K});
      s[3] = pk(c[7:6], a, {nil, W_68FE80, W_68FF00, W_F80000}, {nil, SZ_128, SZ_128, SZ_128K});
      s[4] = pk(c[9:8], a, {nil, nil, W_68FE80, W_002800}, {nil, nil, SZ_128, SZ_2K});
      s[5] = pk(c[11:10], a, {nil, nil, nil, W_68FF80}, {nil, nil, nil, SZ_128});
      s[6] = pk(c[13:12], a, {nil, nil, nil, W_68FF00}, {nil, nil, nil, SZ_128});
      s[7] = 1'b0;
      return s;
   endfunction
   function automatic logic [31:0] lfsr(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task nxt();
      repeat (32) seed = lfsr(seed);
   endtask
   task chk(string nm, logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         num_errors++;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task report_and_stop();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #(50 * 40000);
      num_errors++;
      report_and_stop();
   end
   initial begin
      {rst, psel, penable, pwrite, bus_valid, fetch_access} = 6'h20;
      {paddr, pwdata, bus_addr, seed} = {12'h0, 32'h0, 24'h0, 32'h2151ded1};
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, APB_CTRL_OFS, 32'h0);
      chk("ctrl reset", q, {16'h0, CODE_RESET});
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", {q[30:0], err}, 32'h1);
      for (int i = 0; i < 400; i++) begin
         if (i % 8 == 0) begin
            nxt();
            codes = seed[15:0];
            apb(1'b1, APB_CTRL_OFS, seed);
            apb(1'b0, APB_CTRL_OFS, 32'h0);
            chk("ctrl", q, {16'h0, codes});
         end
         nxt();
         bus_valid <= seed[2:0] != 3'h0;
         bus_addr <= seed[4:3] == 2'h0 ? seed[31:8] : pts[seed[19:16] % 14] + 24'(seed[23:21]) - 24'h4;
         fetch_access <= seed[24];
         repeat (2) @(posedge core_clk);
         #1;
         e = bus_valid ? exp_sel(codes, bus_addr) : 8'h0;
         chk("selects", {24'h0, sel}, {24'h0, e});
         @(posedge core_clk);
         if (seed[25]) begin
            apb(1'b0, APB_STAT_OFS, 32'h0);
            chk("status", q, {24'h0, e});
         end
      end
      chk("devices hit", {24'h0, seen}, 32'h7f);
      report_and_stop();
   end
endmodule
